// ===== design/pas_consts.svh
// Register offsets, field positions, reset values and fixed codes of the start-up sequencer.
`ifndef PAS_CONSTS_SVH
`define PAS_CONSTS_SVH

// Register byte offsets on the AXI4-Lite port.
`define PAS_ADDR_W 12
`define PAS_OFS_CTRL 12'h000
`define PAS_OFS_CMD 12'h004
`define PAS_OFS_STATUS 12'h008
`define PAS_OFS_SPD_PAGE 4'h1

// Control register fields.
`define PAS_CTRL_HOME_X 0
`define PAS_CTRL_HOME_Y 1
`define PAS_CTRL_PROG 2
`define PAS_CTRL_RST_VAL 3'h0

// Command register field: writing one issues a controller reset.
`define PAS_CMD_CTRL_RST 0

// Status register fields.
`define PAS_ST_STATE_LSB 0
`define PAS_ST_DONE_LSB 4
`define PAS_ST_LABEL_LSB 8

// Speed table geometry: two axes, four settings, five fields.
`define PAS_SPD_W 19
`define PAS_SPD_WORDS 40
`define PAS_SPD_PER_AXIS 20
`define PAS_SPD_FIELDS 5
`define PAS_SPD_HOME_SET 3
`define PAS_FLD_MODE 0
`define PAS_FLD_INIT 1
`define PAS_FLD_DRIVE 2
`define PAS_FLD_ACC 3
`define PAS_FLD_DEC 4

// Speed table reset values; a blank setting reads as zero.
`define PAS_S1_DRIVE 19'h00fa0
`define PAS_S2_DRIVE 19'h13880
`define PAS_S3_DRIVE 19'h13880
`define PAS_S4_INIT 19'h00fa0
`define PAS_S4_DRIVE 19'h09c40
`define PAS_ACC_DEFAULT 19'h001f4

// Program labels.
`define PAS_LABEL_W 6
`define PAS_FIRST_LABEL 6'h01

// Bus answers.
`define PAS_RESP_OKAY 2'h0
`define PAS_RESP_SLVERR 2'h2

`endif

// ===== design/pas_pkg.sv
// Types shared by the start-up sequencer and its speed table.
package pas_pkg;

  typedef enum logic [3:0] {
    PAS_IDLE   = 4'h1,
    PAS_HOMING = 4'h2,
    PAS_PROG   = 4'h4,
    PAS_SPARE  = 4'h8
  } pas_state_t;

  typedef enum logic [2:0] {
    PAS_MODE_CONST = 3'h0,
    PAS_MODE_TRAP1 = 3'h1,
    PAS_MODE_TRAP2 = 3'h2,
    PAS_MODE_TRAP3 = 3'h3,
    PAS_MODE_SCUR1 = 3'h4,
    PAS_MODE_SCUR2 = 3'h5
  } pas_mode_t;

  typedef struct packed {
    logic hit;
    logic [5:0] idx;
  } pas_spd_sel_t;

  // Maps a bus address onto a speed table word; fields 5 to 7 of each block are holes.
  function automatic pas_spd_sel_t pas_spd_decode(input logic [11:0] addr);
    pas_spd_sel_t sel;
    sel.hit = (addr[11:8] == 4'h1) && (addr[4:2] < 3'h5) && (addr[1:0] == 2'h0);
    sel.idx = 6'((addr[7] ? 20 : 0) + 5 * addr[6:5] + addr[4:2]);
    return sel;
  endfunction

  // Merges a write into an old word under the byte enables.
  function automatic logic [31:0] pas_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

endpackage

// ===== design/pas_speed_store.sv
// Per-axis table of four speed settings, with the home search speed taken from the fourth.
`timescale 1ns/1ns
`include "pas_consts.svh"

module pas_speed_store (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [5:0] wr_idx_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [3:0] wr_strb_in,
  // Read port
  input wire logic [5:0] rd_idx_in,
  output logic [31:0] rd_data_out,
  // Home search speeds per axis
  output logic [`PAS_SPD_W-1:0] home_init_x_out,
  output logic [`PAS_SPD_W-1:0] home_drive_x_out,
  output logic [`PAS_SPD_W-1:0] home_init_y_out,
  output logic [`PAS_SPD_W-1:0] home_drive_y_out
);
  import pas_pkg::*;

  typedef struct packed {
    logic [`PAS_SPD_WORDS-1:0][`PAS_SPD_W-1:0] word;
  } pas_store_t;

  pas_store_t st;
  pas_store_t next_st;

  function automatic logic [`PAS_SPD_W-1:0] pas_spd_default(input int idx);
    int set;
    int fld;
    set = (idx % `PAS_SPD_PER_AXIS) / `PAS_SPD_FIELDS;
    fld = idx % `PAS_SPD_FIELDS;
    case (fld)
      `PAS_FLD_MODE: begin
        case (set)
          1: pas_spd_default = `PAS_SPD_W'(PAS_MODE_TRAP1);
          2: pas_spd_default = `PAS_SPD_W'(PAS_MODE_SCUR1);
          3: pas_spd_default = `PAS_SPD_W'(PAS_MODE_TRAP2);
          default: pas_spd_default = `PAS_SPD_W'(PAS_MODE_CONST);
        endcase
      end
      `PAS_FLD_INIT: pas_spd_default = (set == 3) ? `PAS_S4_INIT : '0;
      `PAS_FLD_DRIVE: begin
        case (set)
          1: pas_spd_default = `PAS_S2_DRIVE;
          2: pas_spd_default = `PAS_S3_DRIVE;
          3: pas_spd_default = `PAS_S4_DRIVE;
          default: pas_spd_default = `PAS_S1_DRIVE;
        endcase
      end
      `PAS_FLD_ACC: pas_spd_default = (set != 0) ? `PAS_ACC_DEFAULT : '0;
      default: pas_spd_default = '0;
    endcase
  endfunction

  function automatic int pas_home_idx(input int axis, input int fld);
    return axis * `PAS_SPD_PER_AXIS + `PAS_SPD_HOME_SET * `PAS_SPD_FIELDS + fld;
  endfunction

  always_comb begin
    logic [31:0] merged;
    next_st = st;
    merged = pas_merge(32'(st.word[wr_idx_in]), wr_data_in, wr_strb_in);
    if (wr_en_in) begin
      next_st.word[wr_idx_in] = merged[`PAS_SPD_W-1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < `PAS_SPD_WORDS; i++) begin
        st.word[i] <= pas_spd_default(i);
      end
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_out = 32'(st.word[rd_idx_in]);
  // Automatic home search runs on the fourth setting of each axis.
  assign home_init_x_out = st.word[pas_home_idx(0, `PAS_FLD_INIT)];
  assign home_drive_x_out = st.word[pas_home_idx(0, `PAS_FLD_DRIVE)];
  assign home_init_y_out = st.word[pas_home_idx(1, `PAS_FLD_INIT)];
  assign home_drive_y_out = st.word[pas_home_idx(1, `PAS_FLD_DRIVE)];

endmodule  // pas_speed_store

// ===== design/pas_sequencer.sv
// Power-on auto start sequencer: start-up home search and program launch, AXI4-Lite registers.
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "pas_consts.svh"

module pas_sequencer (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // AXI4-Lite write address and data
  input wire logic [`PAS_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [`PAS_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Parallel control connector pins, active low
  input wire logic ext_reset_n_in,
  input wire logic stop_n_in,
  input wire logic [`PAS_LABEL_W-1:0] program_select_inputs_n_in,
  // Home search engine
  input wire logic [1:0] home_done_in,
  output logic [1:0] home_start_out,
  output logic home_abort_out,
  output logic [`PAS_SPD_W-1:0] home_init_x_out,
  output logic [`PAS_SPD_W-1:0] home_drive_x_out,
  output logic [`PAS_SPD_W-1:0] home_init_y_out,
  output logic [`PAS_SPD_W-1:0] home_drive_y_out,
  // Program engine
  input wire logic prog_done_in,
  output logic prog_start_out,
  output logic prog_abort_out,
  output logic [`PAS_LABEL_W-1:0] prog_label_out,
  // Controller reset and sequence state
  output logic ctrl_reset_out,
  output logic seq_busy_out
);
  import pas_pkg::*;

  typedef struct packed {
    // Pin synchronisers.
    logic ext_rst_n_s1;
    logic ext_rst_n_s2;
    logic stop_n_s1;
    logic stop_n_s2;
    logic [`PAS_LABEL_W-1:0] psel_n_s1;
    logic [`PAS_LABEL_W-1:0] psel_n_s2;
    // Settings and sequencing.
    logic [2:0] ctrl;
    logic launch_pend;
    pas_state_t state;
    logic [1:0] home_mask;
    logic [1:0] home_done;
    logic [`PAS_LABEL_W-1:0] label;
    logic [1:0] home_start;
    logic home_abort;
    logic prog_start;
    logic prog_abort;
    logic ctrl_reset;
    logic busy;
    logic [`PAS_SPD_W-1:0] init_x;
    logic [`PAS_SPD_W-1:0] drive_x;
    logic [`PAS_SPD_W-1:0] init_y;
    logic [`PAS_SPD_W-1:0] drive_y;
    // Bus slave.
    logic aw_got;
    logic [`PAS_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pas_seq_t;

  pas_seq_t st;
  pas_seq_t next_st;

  logic spd_wr_en;
  logic [5:0] spd_wr_idx;
  logic [31:0] spd_rd_data;
  logic [`PAS_SPD_W-1:0] spd_init_x;
  logic [`PAS_SPD_W-1:0] spd_drive_x;
  logic [`PAS_SPD_W-1:0] spd_init_y;
  logic [`PAS_SPD_W-1:0] spd_drive_y;
  pas_spd_sel_t wr_sel;
  pas_spd_sel_t rd_sel;

  assign wr_sel = pas_spd_decode(st.aw_addr);
  assign rd_sel = pas_spd_decode(s_axi_araddr_in);
  assign spd_wr_idx = wr_sel.idx;

  pas_speed_store u_speed (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .wr_en_in(spd_wr_en),
    .wr_idx_in(spd_wr_idx),
    .wr_data_in(st.w_data),
    .wr_strb_in(st.w_strb),
    .rd_idx_in(rd_sel.idx),
    .rd_data_out(spd_rd_data),
    .home_init_x_out(spd_init_x),
    .home_drive_x_out(spd_drive_x),
    .home_init_y_out(spd_init_y),
    .home_drive_y_out(spd_drive_y)
  );

  // Open select pins read high, so the label is the inverted pin value; with all pins open it is the first label.
  function automatic logic [`PAS_LABEL_W-1:0] pas_label(input logic [`PAS_LABEL_W-1:0] pins_n);
    logic [`PAS_LABEL_W-1:0] val;
    val = ~pins_n;
    return (val == '0) ? `PAS_FIRST_LABEL : val;
  endfunction

  always_comb begin
    logic do_write;
    logic soft_rst;
    logic abort;
    logic [31:0] ctrl_new;
    logic [2:0] en_now;
    do_write = 1'b0;
    soft_rst = 1'b0;
    abort = 1'b0;
    ctrl_new = '0;
    en_now = '0;
    next_st = st;
    spd_wr_en = 1'b0;

    next_st.ext_rst_n_s1 = ext_reset_n_in;
    next_st.ext_rst_n_s2 = st.ext_rst_n_s1;
    next_st.stop_n_s1 = stop_n_in;
    next_st.stop_n_s2 = st.stop_n_s1;
    next_st.psel_n_s1 = program_select_inputs_n_in;
    next_st.psel_n_s2 = st.psel_n_s1;

    next_st.home_start = 2'h0;
    next_st.home_abort = 1'b0;
    next_st.prog_start = 1'b0;
    next_st.prog_abort = 1'b0;
    next_st.ctrl_reset = 1'b0;

    // Write address and data are taken in either order; the write happens once both are held.
    if (s_axi_awvalid_in && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata_in;
      next_st.w_strb = s_axi_wstrb_in;
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      do_write = 1'b1;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `PAS_RESP_OKAY;
    end

    if (do_write) begin
      if (wr_sel.hit) begin
        spd_wr_en = 1'b1;
      end else if (st.aw_addr == `PAS_OFS_CTRL) begin
        ctrl_new = pas_merge(32'(st.ctrl), st.w_data, st.w_strb);
        // While a start-up step runs any enable can be set but none can be cleared.
        if (st.state != PAS_IDLE) begin
          next_st.ctrl = st.ctrl | ctrl_new[2:0];
        end else begin
          next_st.ctrl = ctrl_new[2:0];
        end
      end else if (st.aw_addr == `PAS_OFS_CMD) begin
        soft_rst = st.w_strb[0] && st.w_data[`PAS_CMD_CTRL_RST];
      end else if (st.aw_addr != `PAS_OFS_STATUS) begin
        next_st.bresp = `PAS_RESP_SLVERR;
      end
    end
    next_st.ctrl_reset = soft_rst;

    // Reads answer one cycle after the address is taken.
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `PAS_RESP_OKAY;
      if (rd_sel.hit) begin
        next_st.rdata = spd_rd_data;
      end else if (s_axi_araddr_in == `PAS_OFS_CTRL) begin
        next_st.rdata = 32'(st.ctrl);
      end else if (s_axi_araddr_in == `PAS_OFS_STATUS) begin
        next_st.rdata = '0;
        next_st.rdata[`PAS_ST_STATE_LSB +: 4] = st.state;
        next_st.rdata[`PAS_ST_DONE_LSB +: 2] = st.home_done;
        next_st.rdata[`PAS_ST_LABEL_LSB +: `PAS_LABEL_W] = st.label;
      end else if (s_axi_araddr_in == `PAS_OFS_CMD) begin
        next_st.rdata = '0;
      end else begin
        next_st.rdata = '0;
        next_st.rresp = `PAS_RESP_SLVERR;
      end
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;

    // Both abort sources; the software reset itself never arms a launch.
    abort = soft_rst || !st.stop_n_s2;
    en_now = st.ctrl;

    if (!st.ext_rst_n_s2) begin
      // The external reset pin holds the sequence off and re-arms it for its release.
      next_st.home_abort = (st.state == PAS_HOMING);
      next_st.prog_abort = (st.state == PAS_PROG);
      next_st.state = PAS_IDLE;
      next_st.launch_pend = 1'b1;
    end else begin
      case (st.state)
        PAS_IDLE: begin
          if (st.launch_pend) begin
            next_st.launch_pend = 1'b0;
            // A stop held at the launch cancels the whole start-up run.
            if (abort) begin
              next_st.state = PAS_IDLE;
            end else if (en_now[`PAS_CTRL_HOME_X] || en_now[`PAS_CTRL_HOME_Y]) begin
              next_st.home_mask = en_now[1:0];
              next_st.home_done = 2'h0;
              next_st.home_start = en_now[1:0];
              next_st.init_x = spd_init_x;
              next_st.drive_x = spd_drive_x;
              next_st.init_y = spd_init_y;
              next_st.drive_y = spd_drive_y;
              next_st.state = PAS_HOMING;
            end else if (en_now[`PAS_CTRL_PROG]) begin
              next_st.label = pas_label(st.psel_n_s2);
              next_st.prog_start = 1'b1;
              next_st.state = PAS_PROG;
            end
          end
        end
        PAS_HOMING: begin
          if (abort) begin
            next_st.home_abort = 1'b1;
            next_st.state = PAS_IDLE;
          end else begin
            next_st.home_done = st.home_done | (home_done_in & st.home_mask);
            // The program waits for every axis that was sent homing.
            if (next_st.home_done == st.home_mask) begin
              if (st.ctrl[`PAS_CTRL_PROG]) begin
                next_st.label = pas_label(st.psel_n_s2);
                next_st.prog_start = 1'b1;
                next_st.state = PAS_PROG;
              end else begin
                next_st.state = PAS_IDLE;
              end
            end
          end
        end
        PAS_PROG: begin
          if (abort) begin
            next_st.prog_abort = 1'b1;
            next_st.state = PAS_IDLE;
          end else if (prog_done_in) begin
            next_st.state = PAS_IDLE;
          end
        end
        default: begin
          next_st.state = PAS_IDLE;
        end
      endcase
    end
    next_st.busy = (next_st.state != PAS_IDLE);
  end

  // Power-up arms the launch, but it is spent on the first edge after release while the settings cleared by reset
  // are still zero, so power-up starts no run; start-up runs need the external reset pin after software sets them.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st <= '0;
      st.ext_rst_n_s1 <= 1'b1;
      st.ext_rst_n_s2 <= 1'b1;
      st.stop_n_s1 <= 1'b1;
      st.stop_n_s2 <= 1'b1;
      st.psel_n_s1 <= '1;
      st.psel_n_s2 <= '1;
      st.ctrl <= `PAS_CTRL_RST_VAL;
      st.launch_pend <= 1'b1;
      st.state <= PAS_IDLE;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready_out = st.awready;
  assign s_axi_wready_out = st.wready;
  assign s_axi_bvalid_out = st.bvalid;
  assign s_axi_bresp_out = st.bresp;
  assign s_axi_arready_out = st.arready;
  assign s_axi_rvalid_out = st.rvalid;
  assign s_axi_rdata_out = st.rdata;
  assign s_axi_rresp_out = st.rresp;
  assign home_start_out = st.home_start;
  assign home_abort_out = st.home_abort;
  assign home_init_x_out = st.init_x;
  assign home_drive_x_out = st.drive_x;
  assign home_init_y_out = st.init_y;
  assign home_drive_y_out = st.drive_y;
  assign prog_start_out = st.prog_start;
  assign prog_abort_out = st.prog_abort;
  assign prog_label_out = st.label;
  assign ctrl_reset_out = st.ctrl_reset;
  assign seq_busy_out = st.busy;

endmodule  // pas_sequencer

// ===== tb/pas_seq_assertions.sv
// Port-level checks on the start-up sequencer.
`timescale 1ns/1ns
`include "pas_consts.svh"

module pas_seq_assertions (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Pins and engine answers
  input wire logic stop_n_in,
  input wire logic [`PAS_LABEL_W-1:0] program_select_inputs_n_in,
  input wire logic [1:0] home_done_in,
  // Sequencer outputs
  input wire logic [1:0] home_start_out,
  input wire logic home_abort_out,
  input wire logic [`PAS_SPD_W-1:0] home_drive_x_out,
  input wire logic prog_start_out,
  input wire logic prog_abort_out,
  input wire logic [`PAS_LABEL_W-1:0] prog_label_out,
  input wire logic ctrl_reset_out,
  input wire logic seq_busy_out
);
  logic rst_d;

  // The home speed check skips the first edge after reset, whose past is stale.
  always_ff @(posedge mclk_in) begin
    rst_d <= reset_in;
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  start_pulse_a:
    assert property (|home_start_out |-> seq_busy_out ##1 home_start_out == 2'h0)
    else $error("home start pulse");
  prog_pulse_a:
    assert property (prog_start_out |-> seq_busy_out ##1 !prog_start_out)
    else $error("program start pulse");
  soft_launch_a:
    assert property (ctrl_reset_out |-> ##1 (home_start_out == 2'h0 && !prog_start_out) [*4])
    else $error("soft reset launched");
  cmd_abort_a:
    assert property (ctrl_reset_out && $past(seq_busy_out) |->
      (home_abort_out || prog_abort_out) && !seq_busy_out)
    else $error("command abort");
  stop_abort_a:
    assert property ((!stop_n_in) [*5] |-> !seq_busy_out)
    else $error("stop abort");
  label_value_a:
    assert property ($stable(program_select_inputs_n_in) [*5] ##0 prog_start_out |->
      prog_label_out == ((program_select_inputs_n_in == 6'h3f) ? 6'h01
      : ~program_select_inputs_n_in))
    else $error("program label");
  prog_wait_a:
    assert property (|home_start_out ##1 (home_done_in == 2'h0) [*3] |-> !prog_start_out)
    else $error("program before homing");
  speed_hold_a:
    assert property (home_start_out == 2'h0 && !rst_d |-> $stable(home_drive_x_out))
    else $error("home speed moved");

  cover property (|home_start_out ##[1:200] prog_start_out);
  cover property (home_abort_out);
  cover property (prog_abort_out);
endmodule // pas_seq_assertions

bind pas_sequencer pas_seq_assertions chk (.mclk_in, .reset_in, .stop_n_in,
  .program_select_inputs_n_in, .home_done_in, .home_start_out, .home_abort_out,
  .home_drive_x_out, .prog_start_out, .prog_abort_out, .prog_label_out,
  .ctrl_reset_out, .seq_busy_out);

// ===== tb/pas_engine_model.sv
// Behavioural home search and program engines on the far side.
`timescale 1ns/1ns

module pas_engine_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Requests
  input wire logic [1:0] home_start_in,
  input wire logic home_abort_in,
  input wire logic prog_start_in,
  input wire logic prog_abort_in,
  input wire logic [7:0] pace_in,
  // Completion reports
  output logic [1:0] home_done_out = 2'h0,
  output logic prog_done_out = 1'b0
);
  int x_left, y_left, p_left;

  // A zero count is idle, so an aborted run reports done only when the abort meets its last count.
  always @(posedge mclk_in) begin
    home_done_out <= {y_left == 1, x_left == 1};
    prog_done_out <= (p_left == 1);
    x_left <= (x_left > 0) ? x_left - 1 : 0;
    y_left <= (y_left > 0) ? y_left - 1 : 0;
    p_left <= (p_left > 0) ? p_left - 1 : 0;
    if (home_start_in[0]) x_left <= pace_in;
    if (home_start_in[1]) y_left <= 2 * pace_in;
    // The program opens with a timer line, so it runs a while before it ends.
    if (prog_start_in) p_left <= 3 * pace_in;
    if (reset_in || home_abort_in) begin
      x_left <= 0;
      y_left <= 0;
    end
    if (reset_in || prog_abort_in) p_left <= 0;
  end
endmodule // pas_engine_model

// ===== tb/testbench.sv
// Self-checking bench for the start-up sequencer.
`timescale 1ns/1ns

module testbench;
  logic mclk_in;
  logic reset_in = 1'b1;
  logic [11:0] s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, home_start_out, home_done_in;
  logic ext_reset_n_in = 1'b1, stop_n_in = 1'b1;
  logic [5:0] program_select_inputs_n_in = 6'h3f, prog_label_out;
  logic prog_done_in, home_abort_out, prog_start_out, prog_abort_out;
  logic ctrl_reset_out, seq_busy_out;
  logic [18:0] home_init_x_out, home_drive_x_out, home_init_y_out, home_drive_y_out;
  logic [7:0] pace = 8'd10;
  int hs_cnt, ps_cnt, hab_cnt, pab_cnt, rst_cnt, cyc, fails, cmp_count;
  logic [1:0] last_bresp;

  pas_sequencer dut (.mclk_in, .reset_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .ext_reset_n_in, .stop_n_in,
    .program_select_inputs_n_in, .home_done_in, .home_start_out, .home_abort_out,
    .home_init_x_out, .home_drive_x_out, .home_init_y_out, .home_drive_y_out,
    .prog_done_in, .prog_start_out, .prog_abort_out, .prog_label_out, .ctrl_reset_out,
    .seq_busy_out);

  pas_engine_model partner (.mclk_in, .reset_in, .home_start_in(home_start_out),
    .home_abort_in(home_abort_out), .prog_start_in(prog_start_out),
    .prog_abort_in(prog_abort_out), .pace_in(pace), .home_done_out(home_done_in),
    .prog_done_out(prog_done_in));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic final_report();
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    hs_cnt <= hs_cnt + int'(|home_start_out);
    ps_cnt <= ps_cnt + int'(prog_start_out);
    hab_cnt <= hab_cnt + int'(home_abort_out);
    pab_cnt <= pab_cnt + int'(prog_abort_out);
    rst_cnt <= rst_cnt + int'(ctrl_reset_out);
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask

  // Ready and valid are sampled mid-cycle so the release lands on the handshake edge.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge mclk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(negedge mclk_in);
      aw = s_axi_awready_out;
      w = s_axi_wready_out;
      b = s_axi_bvalid_out;
      last_bresp = s_axi_bresp_out;
      @(posedge mclk_in);
      if (aw) s_axi_awvalid_in <= 1'b0;
      if (w) s_axi_wvalid_in <= 1'b0;
    end while (!b);
    s_axi_bready_in <= 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic ar, v;
    logic [31:0] got;
    logic [1:0] resp;
    @(posedge mclk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(negedge mclk_in);
      ar = s_axi_arready_out;
      v = s_axi_rvalid_out;
      got = s_axi_rdata_out;
      resp = s_axi_rresp_out;
      @(posedge mclk_in);
      if (ar) s_axi_arvalid_in <= 1'b0;
    end while (!v);
    s_axi_rready_in <= 1'b0;
    chk(n, got, d);
    chk(n, {30'h0, resp}, {30'h0, r});
  endtask

  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 1000 && seq_busy_out !== lvl; i++) @(negedge mclk_in);
  endtask

  task automatic ext_reset(input logic [5:0] pins, input logic [7:0] p);
    @(posedge mclk_in);
    program_select_inputs_n_in <= pins;
    pace <= p;
    ext_reset_n_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    ext_reset_n_in <= 1'b1;
    wait_busy(1'b1);
  endtask

  initial begin
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (20) @(negedge mclk_in);
    chk("power-up launches", hs_cnt + ps_cnt, 0);
    rd_chk("ctrl", 12'h000, 32'h0, 2'h0);
    rd_chk("s4 mode", 12'h160, 32'h2, 2'h0);
    rd_chk("s4 y drive", 12'h1e8, 32'h09c40, 2'h0);
    rd_chk("hole", 12'h114, 32'h0, 2'h2);
    wr(12'h114, 32'h5);
    chk("hole wr", last_bresp, 32'h2);
    wr(12'h164, 32'h7a120);
    chk("wr resp", last_bresp, 32'h0);
    rd_chk("s4 x init", 12'h164, 32'h7a120, 2'h0);
    wr(12'h000, 32'h7);
    wr(12'h004, 32'h1);
    repeat (20) @(negedge mclk_in);
    chk("soft launch", hs_cnt + ps_cnt, 0);
    chk("soft reset", rst_cnt, 1);
    ext_reset(6'h3a, 8'd10);
    chk("both axes", home_start_out, 32'h3);
    chk("init x", home_init_x_out, 32'h7a120);
    chk("drive y", home_drive_y_out, 32'h09c40);
    chk("drive x", home_drive_x_out, 32'h09c40);
    chk("init y", home_init_y_out, 32'h00fa0);
    repeat (15) @(negedge mclk_in);
    chk("wait y", ps_cnt, 0);
    for (int i = 0; i < 300 && ps_cnt == 0; i++) @(negedge mclk_in);
    chk("label", prog_label_out, 32'h5);
    @(posedge mclk_in);
    program_select_inputs_n_in <= 6'h00;
    wait_busy(1'b0);
    chk("label held", prog_label_out, 32'h5);
    ext_reset(6'h3f, 8'd100);
    @(posedge mclk_in);
    stop_n_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    stop_n_in <= 1'b1;
    @(negedge mclk_in);
    chk("stop abort", hab_cnt, 1);
    chk("stop idle", seq_busy_out, 32'h0);
    repeat (400) @(negedge mclk_in);
    chk("no resume prog", ps_cnt, 1);
    chk("no resume home", hs_cnt, 2);
    rd_chk("status", 12'h008, 32'h501, 2'h0);
    wr(12'h000, 32'h4);
    ext_reset(6'h3f, 8'd100);
    chk("prog only", prog_start_out, 32'h1);
    chk("first label", prog_label_out, 32'h1);
    chk("home off", hs_cnt, 2);
    wr(12'h000, 32'h0);
    rd_chk("no cancel", 12'h000, 32'h4, 2'h0);
    wr(12'h004, 32'h1);
    repeat (3) @(negedge mclk_in);
    chk("cmd abort", pab_cnt, 1);
    chk("cmd idle", seq_busy_out, 32'h0);
    wr(12'h000, 32'h0);
    rd_chk("ctrl off", 12'h000, 32'h0, 2'h0);
    final_report();
  end
endmodule // testbench
